// ---- rtl/roa_rtc_ctrl.sv ----
// rtc oscillator control, alarm configuration, alarm compare and interrupt
// Summary of operation
// R01: osc_control bit 7 turns automatic gain control on when set.
// R02: osc_control bit 6 picks crystal when 1, self-oscillate when 0.
// R03: osc_control bit 5 turns oscillator bias doubling on when set.
// R04: bit 4 reads 1 only while oscillation amplitude is sufficient.
// R05: bit 4 reads 0 whenever bias doubling is off.
// R06: bit 3 enables the low-frequency oscillator and overrides the mode bit.
// R07: osc_control bits 2..0 read zero and ignore writes.
// R08: alarm flags set on their alarm and stay set until software clears.
// R09: with clear_on_match set, an alarm 0 event clears the counter.
// R10: alarm_config bits 2, 1, 0 arm alarms 2, 1, 0.
// R11: alarm 0 match value is four bytes at index 0x08, low byte first.
// R12: software disarms alarm 0 before rewriting its match bytes.
// R13: an alarm fires only when armed and the counter equals its match.
// R14: both registers reset to zero.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module roa_rtc_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [roa_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [roa_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_tick_pin,
    input wire logic osc_amp_pin,
    output logic auto_gain_on,
    output logic osc_source_select,
    output logic bias_boost,
    output logic low_freq_osc_select,
    output roa_pkg::roa_src_t osc_clk_src,
    output logic [31:0] counter_value,
    output logic irq
);
    typedef struct packed {
        logic [7:0] osc;
        logic [7:0] cfg;
        logic [31:0] match0;
        logic [31:0] match1;
        logic [31:0] match2;
        logic [31:0] cnt;
        logic [2:0] ist;
        logic [2:0] imsk;
        logic tick_q;
        logic cnt_new;
    } roa_ctrl_st_t;

    roa_ctrl_st_t st_reg;
    roa_ctrl_st_t st_next;
    logic wr_en;
    logic [5:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [5:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [1:0] pin_s;
    logic tick_s;
    logic amp_s;
    logic amp_ok;
    logic [roa_pkg::NUM_ALARMS-1:0] arm;
    logic [roa_pkg::NUM_ALARMS-1:0] hit;
    logic [31:0] match [roa_pkg::NUM_ALARMS];

    roa_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    roa_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({osc_tick_pin, osc_amp_pin}),
        .dout(pin_s)
    );

    assign tick_s = pin_s[1];
    assign amp_s = pin_s[0];
    // amplitude detector is meaningless without bias doubling
    assign amp_ok = amp_s && st_reg.osc[roa_pkg::OSC_BIAS_BIT]; // R04 R05

    assign match[0] = st_reg.match0;
    assign match[1] = st_reg.match1;
    assign match[2] = st_reg.match2;

    // compare only right after a count step, so a parked or rewritten counter cannot refire
    genvar g;
    generate
        for (g = 0; g < roa_pkg::NUM_ALARMS; g++)
        begin : g_alarm
            assign arm[g] = st_reg.cfg[roa_pkg::CFG_ARM_LSB + g]; // R10
            assign hit[g] = arm[g] && st_reg.cnt_new && (st_reg.cnt == match[g]); // R13
        end
    endgenerate

    function automatic logic [31:0] put_bytes(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[b*8 +: 8] = data[b*8 +: 8];
        end
        return res;
    endfunction

    always_comb
    begin
        wr_ok = 1'b0;
        st_next = st_reg;
        st_next.tick_q = tick_s;
        st_next.cnt_new = 1'b0;
        if (tick_s && !st_reg.tick_q)
        begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
            st_next.cnt_new = 1'b1;
        end
        if (wr_en)
        begin
            case (wr_idx)
                roa_pkg::IDX_OSC:
                begin
                    wr_ok = 1'b1;
                    if (wr_strb[0])
                        st_next.osc = wr_data[7:0] & roa_pkg::OSC_WMASK; // R01 R02 R03 R06 R07
                end
                roa_pkg::IDX_CFG:
                begin
                    wr_ok = 1'b1;
                    // flags only clear from software; reserved bit stays 0
                    if (wr_strb[0])
                        st_next.cfg = (wr_data[7:0] & roa_pkg::CFG_ARM_MASK)
                            | (st_reg.cfg & wr_data[7:0] & roa_pkg::CFG_FLAG_MASK); // R08 R10
                end
                roa_pkg::IDX_MATCH0, roa_pkg::IDX_MATCH0 + 6'h01,
                roa_pkg::IDX_MATCH0 + 6'h02, roa_pkg::IDX_MATCH0 + 6'h03:
                begin
                    wr_ok = 1'b1;
                    if (wr_strb[0])
                        st_next.match0[(wr_idx[1:0])*8 +: 8] = wr_data[7:0]; // R11
                end
                roa_pkg::IDX_CNT:
                begin
                    wr_ok = 1'b1;
                    st_next.cnt = put_bytes(st_reg.cnt, wr_data, wr_strb);
                    st_next.cnt_new = 1'b0;
                end
                roa_pkg::IDX_MATCH1:
                begin
                    wr_ok = 1'b1;
                    st_next.match1 = put_bytes(st_reg.match1, wr_data, wr_strb);
                end
                roa_pkg::IDX_MATCH2:
                begin
                    wr_ok = 1'b1;
                    st_next.match2 = put_bytes(st_reg.match2, wr_data, wr_strb);
                end
                roa_pkg::IDX_IST:
                begin
                    wr_ok = 1'b1;
                    if (wr_strb[0])
                        st_next.ist = st_reg.ist & ~wr_data[2:0];
                end
                roa_pkg::IDX_IMSK:
                begin
                    wr_ok = 1'b1;
                    if (wr_strb[0])
                        st_next.imsk = wr_data[2:0];
                end
                default:
                    wr_ok = 1'b0;
            endcase
        end
        // hardware set wins over a same-cycle software clear
        st_next.cfg[roa_pkg::CFG_FLAG_LSB +: 3] = st_next.cfg[roa_pkg::CFG_FLAG_LSB +: 3] | hit; // R08
        st_next.ist = st_next.ist | hit;
        if (hit[0] && st_reg.cfg[roa_pkg::CFG_CLEAR_ON_MATCH_BIT])
            st_next.cnt = roa_pkg::WORD_RESET; // R09
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.osc <= roa_pkg::OSC_RESET; // R14
            st_reg.cfg <= roa_pkg::CFG_RESET; // R14
            st_reg.ist <= roa_pkg::IRQ_RESET;
            st_reg.imsk <= roa_pkg::IRQ_RESET;
        end
        else
            st_reg <= st_next;
    end

    always_comb
    begin
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        case (rd_idx)
            roa_pkg::IDX_OSC:
            begin
                rd_data[7:0] = st_reg.osc;
                rd_data[roa_pkg::OSC_AMP_BIT] = amp_ok; // R04 R07
            end
            roa_pkg::IDX_CFG:
                rd_data[7:0] = st_reg.cfg;
            roa_pkg::IDX_MATCH0, roa_pkg::IDX_MATCH0 + 6'h01,
            roa_pkg::IDX_MATCH0 + 6'h02, roa_pkg::IDX_MATCH0 + 6'h03:
                rd_data[7:0] = st_reg.match0[(rd_idx[1:0])*8 +: 8]; // R11
            roa_pkg::IDX_CNT:
                rd_data = st_reg.cnt;
            roa_pkg::IDX_MATCH1:
                rd_data = st_reg.match1;
            roa_pkg::IDX_MATCH2:
                rd_data = st_reg.match2;
            roa_pkg::IDX_IST:
                rd_data[2:0] = st_reg.ist;
            roa_pkg::IDX_IMSK:
                rd_data[2:0] = st_reg.imsk;
            default:
                rd_ok = 1'b0;
        endcase
    end

    assign auto_gain_on = st_reg.osc[roa_pkg::OSC_AGC_BIT]; // R01
    assign osc_source_select = st_reg.osc[roa_pkg::OSC_OSC_SOURCE_SELECT_BIT];
    assign bias_boost = st_reg.osc[roa_pkg::OSC_BIAS_BIT]; // R03
    assign low_freq_osc_select = st_reg.osc[roa_pkg::OSC_LFO_BIT];
    assign osc_clk_src = st_reg.osc[roa_pkg::OSC_LFO_BIT] ? roa_pkg::ROA_SRC_LFO
        : (st_reg.osc[roa_pkg::OSC_OSC_SOURCE_SELECT_BIT] ? roa_pkg::ROA_SRC_XTAL : roa_pkg::ROA_SRC_SELF); // R02 R06
    assign counter_value = st_reg.cnt;
    assign irq = |(st_reg.ist & st_reg.imsk);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic osc_wr;
    logic cfg_wr;
    assign osc_wr = wr_en && wr_idx == roa_pkg::IDX_OSC && wr_strb[0];
    assign cfg_wr = wr_en && wr_idx == roa_pkg::IDX_CFG && wr_strb[0];
    property p_agc_follow;
        osc_wr |=> auto_gain_on == $past(wr_data[7]);
    endproperty
    a_agc_follow: assert property (p_agc_follow) else $error("gain control bit not taken"); // R01
    property p_src_xtal;
        osc_wr && wr_data[6] && !wr_data[3] |=> osc_clk_src == roa_pkg::ROA_SRC_XTAL;
    endproperty
    a_src_xtal: assert property (p_src_xtal) else $error("crystal source not selected"); // R02
    property p_bias_follow;
        osc_wr |=> bias_boost == $past(wr_data[5]) [*2];
    endproperty
    a_bias_follow: assert property (p_bias_follow) else $error("bias doubling not held"); // R03
    property p_amp_gated;
        rd_idx == roa_pkg::IDX_OSC && !bias_boost |-> rd_data[4] == 1'b0;
    endproperty
    a_amp_gated: assert property (p_amp_gated) else $error("amplitude valid without bias doubling"); // R05
    property p_lfo_override;
        osc_wr && wr_data[3] |=> osc_clk_src == roa_pkg::ROA_SRC_LFO && low_freq_osc_select;
    endproperty
    a_lfo_override: assert property (p_lfo_override) else $error("low-frequency source not taken"); // R06
    property p_low_bits_zero;
        rd_idx == roa_pkg::IDX_OSC |-> rd_data[2:0] == 3'h0;
    endproperty
    a_low_bits_zero: assert property (p_low_bits_zero) else $error("unused osc bits read nonzero"); // R07
    property p_flag_sticky;
        st_reg.cfg[4] && !cfg_wr |=> st_reg.cfg[4];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("alarm 0 flag dropped by itself"); // R08
    property p_auto_clear;
        hit[0] && st_reg.cfg[3] |=> counter_value == 32'h0000_0000;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("counter not cleared on alarm 0"); // R09
    property p_match0_byte;
        wr_en && wr_idx == 6'h09 && wr_strb[0] |=> st_reg.match0[15:8] == $past(wr_data[7:0]);
    endproperty
    a_match0_byte: assert property (p_match0_byte) else $error("match byte 1 not stored"); // R11
    property p_flag_cause;
        $rose(st_reg.cfg[5]) |-> $past(st_reg.cfg[1] && st_reg.cnt_new && st_reg.cnt == st_reg.match1);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("alarm 1 flag without armed match"); // R10 R13
    property p_reset_zero;
        !$past(aresetn) |-> st_reg.osc == 8'h00 && st_reg.cfg == 8'h00 && !irq;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset"); // R14
    c_alarm_match_value_0_hit: cover property (hit[0] && st_reg.cfg[3]);
    c_flag_clear: cover property (st_reg.cfg[6] ##1 !st_reg.cfg[6]);
    c_irq: cover property ($rose(irq));
    c_lfo: cover property (osc_clk_src == roa_pkg::ROA_SRC_LFO);
endmodule

// ---- rtl/roa_pkg.sv ----
// shared constants and types of the rtc oscillator / alarm control block
package roa_pkg;
    localparam int ADDR_W = 8;
    localparam int NUM_ALARMS = 3;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_OSC = 6'h05;
    localparam logic [5:0] IDX_CFG = 6'h07;
    localparam logic [5:0] IDX_MATCH0 = 6'h08;
    localparam logic [5:0] IDX_CNT = 6'h10;
    localparam logic [5:0] IDX_MATCH1 = 6'h11;
    localparam logic [5:0] IDX_MATCH2 = 6'h12;
    localparam logic [5:0] IDX_IST = 6'h13;
    localparam logic [5:0] IDX_IMSK = 6'h14;
    // osc_control fields
    localparam int OSC_AGC_BIT = 7;
    localparam int OSC_OSC_SOURCE_SELECT_BIT = 6;
    localparam int OSC_BIAS_BIT = 5;
    localparam int OSC_AMP_BIT = 4;
    localparam int OSC_LFO_BIT = 3;
    localparam logic [7:0] OSC_WMASK = 8'hf8;
    localparam logic [7:0] OSC_RESET = 8'h00;
    // alarm_config fields
    localparam int CFG_FLAG_LSB = 4;
    localparam int CFG_CLEAR_ON_MATCH_BIT = 3;
    localparam int CFG_ARM_LSB = 0;
    localparam logic [7:0] CFG_ARM_MASK = 8'h0f;
    localparam logic [7:0] CFG_FLAG_MASK = 8'h70;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ROA_SRC_SELF = 2'h0,
        ROA_SRC_XTAL = 2'h1,
        ROA_SRC_LFO = 2'h3
    } roa_src_t;
endpackage

// ---- rtl/roa_sync2.sv ----
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
module roa_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } roa_sync_st_t;

    roa_sync_st_t st_reg;
    roa_sync_st_t st_next;

    // meta feeds only the second stage
    always_comb
    begin
        st_next.meta = din;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign dout = st_reg.stable;
endmodule

// ---- rtl/roa_axil.sv ----
// axi4-lite slave front end: one write and one read under way at a time
`timescale 1ns/10ps
module roa_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [roa_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [roa_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [5:0] wr_idx,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic [5:0] rd_idx,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    typedef struct packed {
        logic aw_have;
        logic w_have;
        logic [5:0] awidx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } roa_axil_st_t;

    roa_axil_st_t st_reg;
    roa_axil_st_t st_next;
    logic aw_take;
    logic w_take;
    logic ar_take;

    // prot is accepted but has no effect on this block
    assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_have && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign wr_en = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
    assign rd_idx = s_axi_araddr[7:2];

    always_comb
    begin
        st_next = st_reg;
        if (aw_take)
        begin
            st_next.aw_have = 1'b1;
            st_next.awidx = s_axi_awaddr[7:2];
        end
        if (w_take)
        begin
            st_next.w_have = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (wr_en)
        begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = wr_ok ? roa_pkg::RESP_OKAY : roa_pkg::RESP_SLVERR;
        end
        else if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;
        if (ar_take)
        begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_data;
            st_next.rresp = rd_ok ? roa_pkg::RESP_OKAY : roa_pkg::RESP_SLVERR;
        end
        else if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;
    assign wr_idx = st_reg.awidx;
    assign wr_data = st_reg.wdata;
    assign wr_strb = st_reg.wstrb;
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the rtc oscillator and alarm control block
`timescale 1ns/10ps
module tb;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata, counter_value;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic osc_tick_pin, osc_amp_pin, auto_gain_on, osc_source_select, bias_boost, low_freq_osc_select, irq;
    roa_pkg::roa_src_t osc_clk_src;
    int bad_count, tests_run;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [33:0] r;
    logic [7:0] v;
    logic a;
    logic [31:0] m, cfg;

    roa_rtc_ctrl dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .osc_tick_pin(osc_tick_pin), .osc_amp_pin(osc_amp_pin),
        .auto_gain_on(auto_gain_on), .osc_source_select(osc_source_select), .bias_boost(bias_boost),
        .low_freq_osc_select(low_freq_osc_select), .osc_clk_src(osc_clk_src),
        .counter_value(counter_value), .irq(irq)
    );

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // bounded wait on the bus; running out is a failure
    task automatic tick_guard(inout int n);
        @(posedge aclk);
        n++;
        if (n > 50)
        begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int n = 0;
        bit done = 0;
        bq.push_back(er);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!done)
        begin
            tick_guard(n);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid;
        end
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [1:0] er = 2'h0);
        int n = 0;
        bit done = 0;
        rq.push_back({er, e});
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        while (!done)
        begin
            tick_guard(n);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid;
        end
    endtask

    // pin pulses are slow against aclk so the synchroniser sees every edge
    task automatic tick(input int k);
        repeat (k)
        begin
            osc_tick_pin <= 1'b1;
            repeat (3) @(posedge aclk);
            osc_tick_pin <= 1'b0;
            repeat (3) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask

    // response watcher: bready and rready stay high, so each valid is one result
    always @(posedge aclk)
    begin
        if (aresetn && s_axi_bvalid)
            chk("bresp", (bq.size() > 0) ? {30'h0, bq.pop_front()} : 32'h3, {30'h0, s_axi_bresp});
        if (aresetn && s_axi_rvalid)
        begin
            r = (rq.size() > 0) ? rq.pop_front() : 34'h3_ffff_ffff;
            chk("rdata", r[31:0], s_axi_rdata);
            chk("rresp", {30'h0, r[33:32]}, {30'h0, s_axi_rresp});
        end
    end

    initial
    begin
        void'($urandom(32'h832a5603));
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, osc_tick_pin, osc_amp_pin} = '0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset pins", 32'h0, {27'h0, auto_gain_on, osc_source_select, bias_boost, low_freq_osc_select, irq});
        rd(roa_pkg::IDX_OSC, 32'h0);
        rd(roa_pkg::IDX_CFG, 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            v = (i == 0) ? 8'hff : (i == 1) ? 8'hdf : 8'($urandom);
            a = (i < 2) ? 1'b1 : 1'($urandom);
            osc_amp_pin <= a;
            wr(roa_pkg::IDX_OSC, {24'($urandom), v});
            rd(roa_pkg::IDX_OSC, {24'h0, v[7:5], v[5] & a, v[3], 3'h0});
            chk("agc", {31'h0, v[7]}, {31'h0, auto_gain_on});
            chk("mode", {31'h0, v[6]}, {31'h0, osc_source_select});
            chk("bias", {31'h0, v[5]}, {31'h0, bias_boost});
            chk("lfo", {31'h0, v[3]}, {31'h0, low_freq_osc_select});
            chk("src", v[3] ? 32'h3 : {31'h0, v[6]}, {30'h0, osc_clk_src});
        end
        wr(6'h3f, 32'h5a, roa_pkg::RESP_SLVERR);
        rd(6'h3f, 32'h0, roa_pkg::RESP_SLVERR);
        wr(roa_pkg::IDX_CFG, 32'h80);
        rd(roa_pkg::IDX_CFG, 32'h0);
        // match reached while disarmed must stay silent
        wr(roa_pkg::IDX_CNT, 32'h0);
        wr(roa_pkg::IDX_MATCH0, 32'h2);
        wr(roa_pkg::IDX_IMSK, 32'h7);
        tick(2);
        chk("counter", 32'h2, counter_value);
        rd(roa_pkg::IDX_CFG, 32'h0);
        chk("irq idle", 32'h0, {31'h0, irq});
        wr(roa_pkg::IDX_MATCH0 + 6'h1, 32'h1);
        rd(roa_pkg::IDX_MATCH0, 32'h2);
        rd(roa_pkg::IDX_MATCH0 + 6'h1, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            m = (k == 0) ? 32'h102 : 32'h2;
            cfg = (32'h1 << k) | ((k == 0) ? 32'h8 : 32'h0);
            if (k > 0)
                wr((k == 1) ? roa_pkg::IDX_MATCH1 : roa_pkg::IDX_MATCH2, m);
            wr(roa_pkg::IDX_CNT, m - 32'h2);
            wr(roa_pkg::IDX_IMSK, 32'h1 << k);
            wr(roa_pkg::IDX_CFG, cfg);
            tick(2);
            chk("irq raised", 32'h1, {31'h0, irq});
            chk("counter", (k == 0) ? 32'h0 : m, counter_value);
            rd(roa_pkg::IDX_CFG, cfg | (32'h10 << k));
            tick(1);
            rd(roa_pkg::IDX_CFG, cfg | (32'h10 << k));
            wr(roa_pkg::IDX_IMSK, 32'h0);
            chk("irq masked", 32'h0, {31'h0, irq});
            wr(roa_pkg::IDX_IMSK, 32'h1 << k);
            chk("irq unmasked", 32'h1, {31'h0, irq});
            wr(roa_pkg::IDX_IST, 32'h1 << k);
            chk("irq cleared", 32'h0, {31'h0, irq});
            wr(roa_pkg::IDX_CFG, 32'h0);
            rd(roa_pkg::IDX_CFG, 32'h0);
        end
        repeat (3) @(posedge aclk);
        final_report();
    end
endmodule
